// >>> design/ubd_pkg.sv
package ubd_pkg;

    // ------------------------------------------------------------------
    // Register offsets and fields
    // ------------------------------------------------------------------
    localparam logic [2:0] UBD_OFF_DATA     = 3'h0;
    localparam logic [2:0] UBD_OFF_IER      = 3'h1;
    localparam int         UBD_CLK_PICK_BIT = 7;
    localparam int         UBD_IER_RX_BIT   = 0;
    localparam int         UBD_IER_TX_BIT   = 1;
    localparam int         UBD_IER_LINE_BIT = 2;
    localparam int         UBD_IER_MODEM_BIT = 3;
    localparam logic [3:0] UBD_IER_USED_MASK = 4'hF;
    localparam logic [7:0] UBD_RST_BYTE     = 8'h00;

    // ------------------------------------------------------------------
    // Baud generator and character timing
    // ------------------------------------------------------------------
    localparam logic [15:0] UBD_DIV_ZERO_EQUIV = 16'h0003;
    localparam logic [3:0]  UBD_OVERSAMPLE_LAST = 4'hF;
    localparam logic [3:0]  UBD_MID_SAMPLE     = 4'h7;
    localparam logic [2:0]  UBD_LAST_BIT       = 3'h7;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [2:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } ubd_bus_req_t;

    typedef struct packed {
        logic modem_change;
        logic line_error;
        logic rx_timeout;
        logic fifo_mode;
    } ubd_irq_src_t;

    typedef enum logic [1:0] {
        UBD_S_IDLE  = 2'b00,
        UBD_S_START = 2'b01,
        UBD_S_DATA  = 2'b10,
        UBD_S_STOP  = 2'b11
    } ubd_ser_state_t;

endpackage : ubd_pkg

// >>> design/ubd_uart_core.sv
`timescale 1ns/1ps

// Function
// - With divisor access clear, offset 0 reads last received byte; resets zero.
// - A hidden receive shift register fills the receive holding register.
// - With divisor access clear, offset 0 writes load the transmit holding register.
// - Transmit shift loads next byte only after the previous one left.
// - With divisor access set, offset 0 is the divisor low byte, resets zero.
// - With divisor access set, offset 1 bits 6:0 hold divisor upper seven bits.
// - Divisor high bit 7 picks 1.8432 MHz (0) or 48 MHz (1) reference.
// - External clock option on makes the pick bit ignored yet still read/write.
// - Enable bit 3 allows the modem status change interrupt.
// - Enable bit 2 allows the line error interrupt; software reads line status.
// - Enable bit 1 allows the transmit holding empty interrupt.
// - Enable bit 0 allows data available, and timeout in FIFO mode.
// - All four enables clear means no interrupt and nothing pending.
// - Disabled interrupts leave status flags updating normally.
// - Enable bits 7:4 are reserved and read zero; all enables reset zero.
// - Line control bit 7 steers offsets 0 and 1 to the divisor latches.
// - Baud generator divides selected reference by divisor giving sixteen times bit rate.
// - Writing either divisor byte reloads the baud counter at once.
// - Interrupt output only drives while the output-2 gate bit is one.
module ubd_uart_core (
    // Clock and reset
    input  wire logic                  core_clk_i,
    input  wire logic                  srst_i,
    // Register port
    input  wire ubd_pkg::ubd_bus_req_t bus_req_i,
    output logic [7:0]                 rdata_o,
    // Controls held in neighbouring registers
    input  wire logic                  divisor_access_bit_i,
    input  wire logic                  irq_output_gate_i,
    input  wire logic                  external_clock_option_i,
    // Baud reference enable pulses
    input  wire logic                  ref_1p8_tick_i,
    input  wire logic                  ref_48_tick_i,
    input  wire logic                  ref_ext_tick_i,
    // Interrupt sources from neighbouring logic
    input  wire ubd_pkg::ubd_irq_src_t irq_src_i,
    // Serial line
    input  wire logic                  serial_rx_i,
    output logic                       serial_tx_o,
    // Status and interrupt
    output logic                       rx_ready_o,
    output logic                       tx_empty_o,
    output logic                       overrun_o,
    output logic                       framing_err_o,
    output logic                       irq_pending_o,
    output logic                       irq_o
);
    import ubd_pkg::*;

    // ------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------
    logic       wr_data;
    logic       rd_data;
    logic       wr_div_lo;
    logic       wr_div_hi;
    logic       wr_ier;
    logic       div_write;

    assign wr_data   = bus_req_i.wr && bus_req_i.addr == UBD_OFF_DATA && !divisor_access_bit_i;
    assign rd_data   = bus_req_i.rd && bus_req_i.addr == UBD_OFF_DATA && !divisor_access_bit_i;
    assign wr_div_lo = bus_req_i.wr && bus_req_i.addr == UBD_OFF_DATA && divisor_access_bit_i;
    assign wr_div_hi = bus_req_i.wr && bus_req_i.addr == UBD_OFF_IER && divisor_access_bit_i;
    assign wr_ier    = bus_req_i.wr && bus_req_i.addr == UBD_OFF_IER && !divisor_access_bit_i;
    assign div_write = wr_div_lo || wr_div_hi;

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    logic [7:0] rbr_r, rbr_nxt;
    logic [7:0] thr_r, thr_nxt;
    logic [7:0] dll_r, dll_nxt;
    logic [7:0] dlm_r, dlm_nxt;
    logic [3:0] ier_r, ier_nxt;
    logic [7:0] rdata_nxt;
    logic       rx_ready_r, rx_ready_nxt;
    logic       tx_empty_r, tx_empty_nxt;
    logic       rx_commit;
    logic       tx_load;
    logic [7:0] rx_shift_r;

    always_comb begin
        dll_nxt   = wr_div_lo ? bus_req_i.wdata : dll_r;
        dlm_nxt   = wr_div_hi ? bus_req_i.wdata : dlm_r;
        ier_nxt   = wr_ier ? (bus_req_i.wdata[3:0] & UBD_IER_USED_MASK) : ier_r;
        thr_nxt   = wr_data ? bus_req_i.wdata : thr_r;
        rbr_nxt   = rx_commit ? rx_shift_r : rbr_r;
        // An arriving byte wins over the read that clears ready.
        rx_ready_nxt = rx_commit ? 1'b1 : (rd_data ? 1'b0 : rx_ready_r);
        // A new write keeps the holding register full even if it loads this cycle.
        tx_empty_nxt = wr_data ? 1'b0 : (tx_load ? 1'b1 : tx_empty_r);
        rdata_nxt = rdata_o;
        if (bus_req_i.rd) begin
            case (bus_req_i.addr)
                UBD_OFF_DATA: rdata_nxt = divisor_access_bit_i ? dll_r : rbr_r;
                UBD_OFF_IER:  rdata_nxt = divisor_access_bit_i ? dlm_r : {4'h0, ier_r};
                default:      rdata_nxt = UBD_RST_BYTE;
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            rbr_r      <= UBD_RST_BYTE;
            thr_r      <= UBD_RST_BYTE;
            dll_r      <= UBD_RST_BYTE;
            dlm_r      <= UBD_RST_BYTE;
            ier_r      <= 4'h0;
            rdata_o    <= UBD_RST_BYTE;
            rx_ready_r <= 1'b0;
            tx_empty_r <= 1'b1;
        end else begin
            rbr_r      <= rbr_nxt;
            thr_r      <= thr_nxt;
            dll_r      <= dll_nxt;
            dlm_r      <= dlm_nxt;
            ier_r      <= ier_nxt;
            rdata_o    <= rdata_nxt;
            rx_ready_r <= rx_ready_nxt;
            tx_empty_r <= tx_empty_nxt;
        end
    end

    assign rx_ready_o = rx_ready_r;
    assign tx_empty_o = tx_empty_r;

    // ------------------------------------------------------------------
    // Baud generator
    // ------------------------------------------------------------------
    // A zero divisor divides by three, so the counter never stalls.
    logic [15:0] eff_div;
    logic [15:0] eff_div_new;
    logic [15:0] baud_cnt_r, baud_cnt_nxt;
    logic        ref_tick;
    logic        tick16;

    assign eff_div     = ({dlm_r[6:0], dll_r} == 15'h0) ? UBD_DIV_ZERO_EQUIV : {1'b0, dlm_r[6:0], dll_r};
    assign eff_div_new = ({dlm_nxt[6:0], dll_nxt} == 15'h0) ? UBD_DIV_ZERO_EQUIV
                                                             : {1'b0, dlm_nxt[6:0], dll_nxt};
    assign ref_tick    = external_clock_option_i ? ref_ext_tick_i
                       : (dlm_r[UBD_CLK_PICK_BIT] ? ref_48_tick_i : ref_1p8_tick_i);
    assign tick16      = ref_tick && !div_write && baud_cnt_r <= 16'h0001;

    always_comb begin
        baud_cnt_nxt = baud_cnt_r;
        if (div_write) begin
            baud_cnt_nxt = eff_div_new;
        end else if (ref_tick) begin
            baud_cnt_nxt = (baud_cnt_r <= 16'h0001) ? eff_div : baud_cnt_r - 16'h0001;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            baud_cnt_r <= UBD_DIV_ZERO_EQUIV;
        end else begin
            baud_cnt_r <= baud_cnt_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------------
    ubd_ser_state_t rx_st_r, rx_st_nxt;
    logic [3:0]     rx_ph_r, rx_ph_nxt;
    logic [2:0]     rx_idx_r, rx_idx_nxt;
    logic [7:0]     rx_shift_nxt;
    logic           overrun_nxt;
    logic           framing_nxt;

    always_comb begin
        rx_st_nxt    = rx_st_r;
        rx_ph_nxt    = rx_ph_r;
        rx_idx_nxt   = rx_idx_r;
        rx_shift_nxt = rx_shift_r;
        rx_commit    = 1'b0;
        overrun_nxt  = 1'b0;
        framing_nxt  = 1'b0;
        if (tick16) begin
            rx_ph_nxt = rx_ph_r + 4'h1;
            case (rx_st_r)
                UBD_S_IDLE: begin
                    rx_ph_nxt = 4'h0;
                    if (!serial_rx_i) begin
                        rx_st_nxt = UBD_S_START;
                    end
                end
                UBD_S_START: begin
                    if (rx_ph_r == UBD_MID_SAMPLE) begin
                        rx_ph_nxt  = 4'h0;
                        rx_idx_nxt = 3'h0;
                        rx_st_nxt  = serial_rx_i ? UBD_S_IDLE : UBD_S_DATA;
                    end
                end
                UBD_S_DATA: begin
                    if (rx_ph_r == UBD_OVERSAMPLE_LAST) begin
                        rx_shift_nxt = {serial_rx_i, rx_shift_r[7:1]};
                        rx_idx_nxt   = rx_idx_r + 3'h1;
                        if (rx_idx_r == UBD_LAST_BIT) begin
                            rx_st_nxt = UBD_S_STOP;
                        end
                    end
                end
                UBD_S_STOP: begin
                    if (rx_ph_r == UBD_OVERSAMPLE_LAST) begin
                        rx_st_nxt = UBD_S_IDLE;
                        if (serial_rx_i) begin
                            rx_commit   = 1'b1;
                            overrun_nxt = rx_ready_r && !rd_data;
                        end else begin
                            framing_nxt = 1'b1;
                        end
                    end
                end
                default: rx_st_nxt = UBD_S_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            rx_st_r       <= UBD_S_IDLE;
            rx_ph_r       <= 4'h0;
            rx_idx_r      <= 3'h0;
            rx_shift_r    <= UBD_RST_BYTE;
            overrun_o     <= 1'b0;
            framing_err_o <= 1'b0;
        end else begin
            rx_st_r       <= rx_st_nxt;
            rx_ph_r       <= rx_ph_nxt;
            rx_idx_r      <= rx_idx_nxt;
            rx_shift_r    <= rx_shift_nxt;
            overrun_o     <= overrun_nxt;
            framing_err_o <= framing_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------------
    ubd_ser_state_t tx_st_r, tx_st_nxt;
    logic [3:0]     tx_ph_r, tx_ph_nxt;
    logic [2:0]     tx_idx_r, tx_idx_nxt;
    logic [7:0]     tx_shift_r, tx_shift_nxt;
    logic           tx_line_nxt;

    // Loading waits for idle, which is only reached after the stop bit.
    assign tx_load = tx_st_r == UBD_S_IDLE && !tx_empty_r;

    always_comb begin
        tx_st_nxt    = tx_st_r;
        tx_ph_nxt    = tx_ph_r;
        tx_idx_nxt   = tx_idx_r;
        tx_shift_nxt = tx_shift_r;
        tx_line_nxt  = serial_tx_o;
        case (tx_st_r)
            UBD_S_IDLE: begin
                tx_line_nxt = 1'b1;
                if (tx_load) begin
                    tx_shift_nxt = thr_r;
                    tx_ph_nxt    = 4'h0;
                    tx_st_nxt    = UBD_S_START;
                    tx_line_nxt  = 1'b0;
                end
            end
            UBD_S_START: begin
                if (tick16) begin
                    tx_ph_nxt = tx_ph_r + 4'h1;
                    if (tx_ph_r == UBD_OVERSAMPLE_LAST) begin
                        tx_st_nxt   = UBD_S_DATA;
                        tx_idx_nxt  = 3'h0;
                        tx_line_nxt = tx_shift_r[0];
                    end
                end
            end
            UBD_S_DATA: begin
                if (tick16) begin
                    tx_ph_nxt = tx_ph_r + 4'h1;
                    if (tx_ph_r == UBD_OVERSAMPLE_LAST) begin
                        tx_idx_nxt   = tx_idx_r + 3'h1;
                        tx_shift_nxt = {1'b0, tx_shift_r[7:1]};
                        if (tx_idx_r == UBD_LAST_BIT) begin
                            tx_st_nxt   = UBD_S_STOP;
                            tx_line_nxt = 1'b1;
                        end else begin
                            tx_line_nxt = tx_shift_r[1];
                        end
                    end
                end
            end
            UBD_S_STOP: begin
                if (tick16) begin
                    tx_ph_nxt = tx_ph_r + 4'h1;
                    if (tx_ph_r == UBD_OVERSAMPLE_LAST) begin
                        tx_st_nxt = UBD_S_IDLE;
                    end
                end
            end
            default: tx_st_nxt = UBD_S_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            tx_st_r     <= UBD_S_IDLE;
            tx_ph_r     <= 4'h0;
            tx_idx_r    <= 3'h0;
            tx_shift_r  <= UBD_RST_BYTE;
            serial_tx_o <= 1'b1;
        end else begin
            tx_st_r     <= tx_st_nxt;
            tx_ph_r     <= tx_ph_nxt;
            tx_idx_r    <= tx_idx_nxt;
            tx_shift_r  <= tx_shift_nxt;
            serial_tx_o <= tx_line_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt gating
    // ------------------------------------------------------------------
    // Enables only gate the request; the flags underneath run regardless.
    assign irq_pending_o = (ier_r[UBD_IER_RX_BIT] &&
                            (rx_ready_r || (irq_src_i.fifo_mode && irq_src_i.rx_timeout)))
                         || (ier_r[UBD_IER_TX_BIT] && tx_empty_r)
                         || (ier_r[UBD_IER_LINE_BIT] && irq_src_i.line_error)
                         || (ier_r[UBD_IER_MODEM_BIT] && irq_src_i.modem_change);
    assign irq_o = irq_output_gate_i && irq_pending_o;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_rbr_read;
        @(posedge core_clk_i) disable iff (srst_i)
        rd_data |=> rdata_o == $past(rbr_r);
    endproperty
    a_rbr_read: assert property (p_rbr_read) else $error("receive read data wrong");

    property p_ier_reserved;
        @(posedge core_clk_i) disable iff (srst_i)
        (bus_req_i.rd && bus_req_i.addr == UBD_OFF_IER && !divisor_access_bit_i) |=> rdata_o[7:4] == 4'h0;
    endproperty
    a_ier_reserved: assert property (p_ier_reserved) else $error("reserved enable bits not zero");

    property p_irq_gate;
        @(posedge core_clk_i) disable iff (srst_i)
        !irq_output_gate_i |-> !irq_o;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("interrupt driven with gate low");

    property p_no_enable_no_irq;
        @(posedge core_clk_i) disable iff (srst_i)
        ier_r == 4'h0 |-> !irq_pending_o && !irq_o;
    endproperty
    a_no_enable_no_irq: assert property (p_no_enable_no_irq) else $error("pending with enables clear");

    property p_div_reload;
        @(posedge core_clk_i) disable iff (srst_i)
        div_write |=> baud_cnt_r == {1'b0, dlm_r[6:0], dll_r} || baud_cnt_r == UBD_DIV_ZERO_EQUIV;
    endproperty
    a_div_reload: assert property (p_div_reload) else $error("divisor write did not reload counter");

    property p_thr_write_clears_empty;
        @(posedge core_clk_i) disable iff (srst_i)
        wr_data |=> !tx_empty_r && thr_r == $past(bus_req_i.wdata);
    endproperty
    a_thr_write_clears_empty: assert property (p_thr_write_clears_empty) else $error("empty not cleared");

    property p_load_only_idle;
        @(posedge core_clk_i) disable iff (srst_i)
        (tx_st_r == UBD_S_STOP) |=> tx_shift_r == $past(tx_shift_r);
    endproperty
    a_load_only_idle: assert property (p_load_only_idle) else $error("shift reloaded before stop done");

    // A start bit lasts sixteen oversample ticks; counting them keeps the check bounded at any divisor.
    logic [4:0] start_ticks_r, start_ticks_nxt;

    always_comb begin
        start_ticks_nxt = start_ticks_r;
        if (tx_st_r != UBD_S_START) begin
            start_ticks_nxt = 5'h00;
        end else if (tick16) begin
            start_ticks_nxt = start_ticks_r + 5'h01;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            start_ticks_r <= 5'h00;
        end else begin
            start_ticks_r <= start_ticks_nxt;
        end
    end

    property p_start_bounded;
        @(posedge core_clk_i) disable iff (srst_i)
        (tx_st_r == UBD_S_START) |-> start_ticks_r <= {1'b0, UBD_OVERSAMPLE_LAST};
    endproperty
    a_start_bounded: assert property (p_start_bounded) else $error("start bit too long");

    property p_first_bit;
        @(posedge core_clk_i) disable iff (srst_i)
        (tx_st_r == UBD_S_START && tx_st_nxt == UBD_S_DATA) |=> serial_tx_o == $past(tx_shift_r[0]);
    endproperty
    a_first_bit: assert property (p_first_bit) else $error("first data bit is not bit 0");

    property p_rx_commit;
        @(posedge core_clk_i) disable iff (srst_i)
        rx_commit |=> rx_ready_r && rbr_r == $past(rx_shift_r);
    endproperty
    a_rx_commit: assert property (p_rx_commit) else $error("received byte not delivered");

    property p_rd_clears_ready;
        @(posedge core_clk_i) disable iff (srst_i)
        (rd_data && !rx_commit) |=> !rx_ready_r;
    endproperty
    a_rd_clears_ready: assert property (p_rd_clears_ready) else $error("read did not clear ready");

    property p_clk_pick;
        @(posedge core_clk_i) disable iff (srst_i)
        (!external_clock_option_i && !dlm_r[UBD_CLK_PICK_BIT]) |-> ref_tick == ref_1p8_tick_i;
    endproperty
    a_clk_pick: assert property (p_clk_pick) else $error("wrong baud reference");

endmodule : ubd_uart_core

// >>> verification/tb_top.sv
`timescale 1ns/1ps

module tb_top;
    import ubd_pkg::*;
    logic          clk = 0, srst = 1, dab = 0, gate = 0, ext = 0;
    logic          r18 = 0, r48 = 0, rex = 0, rxl, txl;
    logic          rdy, emp, ovr, fer, pend, irq;
    logic [7:0]    rdata, q;
    ubd_bus_req_t  req = '0;
    ubd_irq_src_t  src = '0;
    int            fail_count = 0, compares = 0, cyc = 0;
    logic          ovr_seen = 0, fer_seen = 0;
    logic [7:0]    last_rx = 8'h00;

    ubd_uart_core ubd_uart_core_inst (.core_clk_i(clk), .srst_i(srst), .bus_req_i(req), .rdata_o(rdata),
        .divisor_access_bit_i(dab), .irq_output_gate_i(gate), .external_clock_option_i(ext),
        .ref_1p8_tick_i(r18), .ref_48_tick_i(r48), .ref_ext_tick_i(rex), .irq_src_i(src),
        .serial_rx_i(rxl), .serial_tx_o(txl), .rx_ready_o(rdy), .tx_empty_o(emp),
        .overrun_o(ovr), .framing_err_o(fer), .irq_pending_o(pend), .irq_o(irq));
    ubd_serial_partner ubd_serial_partner_inst (.core_clk_i(clk), .serial_tx_i(txl), .serial_rx_o(rxl));

    initial forever #25 clk = ~clk;
    // Reference rates: 48 MHz pick every cycle, 1.8432 MHz pick every 4th, external every 2nd.
    always @(negedge clk) begin
        cyc <= cyc + 1;
        r48 <= 1'b1;
        r18 <= (cyc % 4 == 0);
        rex <= (cyc % 2 == 0);
    end

    // Error outputs are one-cycle pulses, so they are latched here for later checks.
    always @(negedge clk) begin
        if (ovr === 1'b1) ovr_seen <= 1'b1;
        if (fer === 1'b1) fer_seen <= 1'b1;
    end

    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        compares++;
        if (s !== e) begin
            fail_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk

    task automatic bus(input logic [2:0] a, input logic w, input logic [7:0] d);
        @(negedge clk);
        req = '{addr: a, wr: w, rd: !w, wdata: d};
        @(negedge clk);
        req.wr = 1'b0;
        req.rd = 1'b0;
        q = rdata;
    endtask : bus

    task automatic wait_tx(input int n);
        for (int i = 0; i < 4000 && ubd_serial_partner_inst.got_q.size() < n; i++) @(negedge clk);
    endtask : wait_tx

    task automatic regs_case();
        bus(0, 0, 0); chk(q, 8'h00);
        bus(1, 0, 0); chk(q, 8'h00);
        bus(3, 0, 0); chk(q, 8'h00);
        dab = 1;
        bus(0, 0, 0); chk(q, 8'h00);
        bus(1, 0, 0); chk(q, 8'h00);
        bus(0, 1, 8'hA5); bus(0, 0, 0); chk(q, 8'hA5);
        bus(1, 1, 8'hD5); bus(1, 0, 0); chk(q, 8'hD5);
        ext = 1; bus(1, 0, 0); chk(q, 8'hD5);
        ext = 0; dab = 0;
        bus(1, 1, 8'hFF); bus(1, 0, 0); chk(q, 8'h0F);
    endtask : regs_case

    task automatic irq_one(input logic [7:0] ier, input logic [3:0] s, input logic e);
        bus(1, 1, ier);
        src = s; gate = 0;
        @(negedge clk); chk(irq, 0);
        chk(pend, e);
        gate = 1;
        @(negedge clk); chk(irq, e);
    endtask : irq_one

    task automatic irq_case();
        irq_one(8'h00, 4'hF, 0);
        irq_one(8'h08, 4'h8, 1); irq_one(8'h08, 4'h7, 0);
        irq_one(8'h04, 4'h4, 1); irq_one(8'h04, 4'hB, 0);
        irq_one(8'h01, 4'h3, 1); irq_one(8'h01, 4'h2, 0);
        irq_one(8'h02, 4'h0, 1);
        bus(1, 1, 8'h00);
    endtask : irq_case

    // Programs pick bit and divisor 1, then sends the given bytes with a one-cycle gap.
    task automatic tx_case(input logic pick, input logic x, input int bc, input logic [7:0] a, input logic [7:0] b);
        ext = x; dab = 1;
        bus(1, 1, {pick, 7'h00});
        bus(0, 1, 8'h01);
        dab = 0;
        ubd_serial_partner_inst.bit_cycles = bc;
        ubd_serial_partner_inst.got_q.delete();
        bus(0, 1, a); chk(emp, 0);
        bus(0, 1, b); chk(emp, 0);
        bus(0, 0, 0); chk(q, last_rx);
        wait_tx(2);
        chk(8'(ubd_serial_partner_inst.got_q.size()), 8'h02);
        chk(ubd_serial_partner_inst.got_q[0], a);
        chk(ubd_serial_partner_inst.got_q[1], b);
        // The last stop bit must drain before the next case changes the divisor.
        repeat (2 * bc) @(negedge clk);
    endtask : tx_case

    task automatic rx_case();
        int i;
        ubd_serial_partner_inst.send(8'hC3, 1'b1);
        for (i = 0; i < 400 && rdy !== 1'b1; i++) @(negedge clk);
        chk(rdy, 1);
        chk(ovr_seen, 0);
        bus(0, 0, 0); chk(q, 8'hC3);
        chk(rdy, 0);
        // Second byte arrives unread: overrun pulse, newest byte kept.
        ubd_serial_partner_inst.send(8'h5A, 1'b1);
        ubd_serial_partner_inst.send(8'h0F, 1'b1);
        chk(ovr_seen, 1);
        bus(0, 0, 0); chk(q, 8'h0F);
        // A low stop bit drops the byte and leaves the holding register alone.
        ubd_serial_partner_inst.send(8'hF0, 1'b0);
        chk(fer_seen, 1);
        chk(rdy, 0);
        bus(0, 0, 0); chk(q, 8'h0F);
        last_rx = 8'h0F;
    endtask : rx_case

    task automatic final_report();
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : final_report

    initial begin
        repeat (6) @(negedge clk);
        srst = 0;
        chk(emp, 1);
        regs_case();
        irq_case();
        tx_case(1, 0, 16, 8'h35, 8'hCA);
        rx_case();
        tx_case(0, 0, 64, 8'h96, 8'h01);
        tx_case(0, 1, 32, 8'h5C, 8'h80);
        final_report();
    end

    initial begin
        #2000000;
        fail_count++;
        final_report();
    end
endmodule : tb_top

// >>> verification/ubd_serial_partner.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Remote serial device, 8N1, bit time set in core clock cycles.
// ----------------------------------------------------------------
module ubd_serial_partner (
    // Clock
    input  wire logic core_clk_i,
    // Serial line
    input  wire logic serial_tx_i,
    output logic      serial_rx_o
);
    int         bit_cycles = 16;
    logic [7:0] shift_r;
    logic [7:0] got_q[$];

    initial serial_rx_o = 1'b1;

    // A low stop level makes a framing error; one idle bit always follows the frame.
    task automatic send(input logic [7:0] b, input logic stop);
        @(negedge core_clk_i) serial_rx_o = 1'b0;
        repeat (bit_cycles) @(negedge core_clk_i);
        for (int i = 0; i < 8; i++) begin
            serial_rx_o = b[i];
            repeat (bit_cycles) @(negedge core_clk_i);
        end
        serial_rx_o = stop;
        repeat (bit_cycles) @(negedge core_clk_i);
        serial_rx_o = 1'b1;
        repeat (bit_cycles) @(negedge core_clk_i);
    endtask : send

    // Samples mid-bit from the start edge, so a wrong baud reference garbles the byte.
    always begin
        @(negedge serial_tx_i);
        repeat (bit_cycles / 2) @(posedge core_clk_i);
        for (int i = 0; i < 8; i++) begin
            repeat (bit_cycles) @(posedge core_clk_i);
            shift_r[i] = serial_tx_i;
        end
        got_q.push_back(shift_r);
        repeat (bit_cycles) @(posedge core_clk_i);
    end
endmodule : ubd_serial_partner
